// *** rtl/ops_clock_select.sv ***
// oscillator source selection, dividers and pll control with a register port
// assumes oscillator and vco edges arrive as one-cycle ticks synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module ops_clock_select #(
  parameter logic [23:0] FAST_RC_KHZ = 24'd8000,
  parameter logic [23:0] LOW_POWER_RC_KHZ = 24'd32,
  parameter logic [23:0] SECONDARY_KHZ = 24'd33
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fast_rc_tick,
  input wire logic low_power_rc_tick,
  input wire logic secondary_osc_tick,
  input wire logic primary_osc_tick,
  input wire logic pll_vco_tick,
  input wire logic osc_pin_gpio_out,
  input wire logic osc_pin_gpio_oe,
  output logic osc_tick,
  output logic instruction_clock,
  output logic pll_ref_tick,
  output logic pll_enable,
  output logic [9:0] pll_feedback_factor,
  output logic [1:0] primary_osc_drive,
  output logic second_osc_pin_out,
  output logic second_osc_pin_oe
);
  import ops_pkg::*;

  logic [2:0] initial_osc_source_sel;
  logic [1:0] primary_osc_mode_sel;
  logic osc_pin_function_sel;
  logic [4:0] pll_input_divider_sel;
  logic [8:0] pll_feedback_multiplier_sel;
  logic [1:0] pll_output_divider_sel;
  logic [2:0] fast_rc_div_n_sel;
  logic [23:0] primary_ref_khz;
  logic [31:0] next_readdata;
  logic [31:0] osc_freq_khz;
  logic vco_in_ok;
  logic vco_out_ok;
  logic [5:0] prescale_factor;
  logic [9:0] mult_factor;
  logic [3:0] postscale_factor;
  logic [5:0] pre_cnt;
  logic [3:0] post_cnt;
  logic [4:0] div16_cnt;
  logic [6:0] divn_cnt;
  logic instr_phase;
  logic src_pll;
  logic src_primary;
  logic ref_tick;
  logic next_osc_tick;
  logic wr_hit;
  ops_src_t src;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // output divider factor: 0 -> 2, 1 -> 4, others -> 8
  function automatic logic [3:0] post_factor(input logic [1:0] sel);
    unique case (sel)
      2'b00: return 4'd2;
      2'b01: return 4'd4;
      2'b10: return 4'd8;
      2'b11: return 4'd8;
    endcase
  endfunction

  assign src = ops_src_t'(initial_osc_source_sel);
  assign wr_hit = avs_write && !avs_waitrequest;
  assign prescale_factor = {1'b0, pll_input_divider_sel} + {1'b0, PRE_OFFSET};
  assign mult_factor = {1'b0, pll_feedback_multiplier_sel} + MULT_OFFSET;
  assign postscale_factor = post_factor(pll_output_divider_sel);
  assign src_pll = (src == OPS_FAST_RC_PLL) || (src == OPS_PRIMARY_PLL);
  assign src_primary = (src == OPS_PRIMARY) || (src == OPS_PRIMARY_PLL);
  // primary mode 11 keeps the primary oscillator quiet
  assign ref_tick = src_primary ? (primary_osc_tick && primary_osc_mode_sel != OPS_PRIMARY_OFF)
                                : fast_rc_tick;

  // one-cycle bus answer; a write lands at the edge that sees waitrequest low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // read data loaded once, at the edge that raises the answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // status and frequency words are read-only; writes to them are dropped
  always_comb begin
    next_readdata = 32'h00000000;
    unique case (avs_address)
      OFS_OSC_CFG: begin
        next_readdata[SRC_LSB +: 3] = initial_osc_source_sel;
        next_readdata[MODE_LSB +: 2] = primary_osc_mode_sel;
        next_readdata[PINFN_BIT] = osc_pin_function_sel;
      end
      OFS_PLL_CFG: begin
        next_readdata[PRE_LSB +: 5] = pll_input_divider_sel;
        next_readdata[MULT_LSB +: 9] = pll_feedback_multiplier_sel;
        next_readdata[POST_LSB +: 2] = pll_output_divider_sel;
      end
      OFS_FRC_DIV: next_readdata[2:0] = fast_rc_div_n_sel;
      OFS_REF_KHZ: next_readdata[23:0] = primary_ref_khz;
      OFS_STATUS: next_readdata[4:0] = {vco_out_ok, vco_in_ok, pll_enable, instr_phase, osc_tick};
      OFS_FREQ: next_readdata = osc_freq_khz;
      default: next_readdata = 32'h00000000;
    endcase
  end

  // configuration registers; erased defaults pick fast rc divide-by-n
  always_ff @(posedge sys_clk) begin
    logic [31:0] v;
    v = be_merge({26'h0, osc_pin_function_sel, primary_osc_mode_sel, initial_osc_source_sel},
                 avs_writedata, avs_byteenable);
    if (rst) begin
      initial_osc_source_sel <= SRC_RESET;
      primary_osc_mode_sel <= MODE_RESET;
      osc_pin_function_sel <= PINFN_RESET;
    end else if (wr_hit && avs_address == OFS_OSC_CFG) begin
      initial_osc_source_sel <= v[SRC_LSB +: 3];
      primary_osc_mode_sel <= v[MODE_LSB +: 2];
      osc_pin_function_sel <= v[PINFN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    logic [31:0] v;
    v = 32'h00000000;
    v[PRE_LSB +: 5] = pll_input_divider_sel;
    v[MULT_LSB +: 9] = pll_feedback_multiplier_sel;
    v[POST_LSB +: 2] = pll_output_divider_sel;
    v = be_merge(v, avs_writedata, avs_byteenable);
    if (rst) begin
      pll_input_divider_sel <= PRE_RESET;
      pll_feedback_multiplier_sel <= MULT_RESET;
      pll_output_divider_sel <= POST_RESET;
    end else if (wr_hit && avs_address == OFS_PLL_CFG) begin
      pll_input_divider_sel <= v[PRE_LSB +: 5];
      pll_feedback_multiplier_sel <= v[MULT_LSB +: 9];
      pll_output_divider_sel <= v[POST_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk) begin
    logic [31:0] v;
    v = be_merge({29'h0, fast_rc_div_n_sel}, avs_writedata, avs_byteenable);
    if (rst) begin
      fast_rc_div_n_sel <= FRC_DIV_RESET;
    end else if (wr_hit && avs_address == OFS_FRC_DIV) begin
      fast_rc_div_n_sel <= v[2:0];
    end
  end

  // primary reference only feeds the frequency estimate
  always_ff @(posedge sys_clk) begin
    logic [31:0] v;
    v = be_merge({8'h00, primary_ref_khz}, avs_writedata, avs_byteenable);
    if (rst) begin
      primary_ref_khz <= REF_KHZ_RESET;
    end else if (wr_hit && avs_address == OFS_REF_KHZ) begin
      primary_ref_khz <= v[23:0];
    end
  end

  // pll reference divider, then vco ticks divided by the output factor
  // counters park at zero outside pll sources so the first reference tick is clean
  always_ff @(posedge sys_clk) begin
    if (rst || !src_pll) begin
      pre_cnt <= 6'h00;
      pll_ref_tick <= 1'b0;
    end else begin
      pll_ref_tick <= 1'b0;
      if (ref_tick) begin
        if (pre_cnt >= prescale_factor - 6'h01) begin
          pre_cnt <= 6'h00;
          pll_ref_tick <= 1'b1;
        end else begin
          pre_cnt <= pre_cnt + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !src_pll) begin
      post_cnt <= 4'h0;
    end else if (pll_vco_tick) begin
      post_cnt <= (post_cnt >= postscale_factor - 4'h1) ? 4'h0 : post_cnt + 4'h1;
    end
  end

  // fast rc dividers free-run; divide-by-n is 2 to the power n
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div16_cnt <= 5'h00;
      divn_cnt <= 7'h00;
    end else if (fast_rc_tick) begin
      div16_cnt <= (div16_cnt >= DIV16_LAST) ? 5'h00 : div16_cnt + 5'h01;
      divn_cnt <= (divn_cnt >= (7'h01 << fast_rc_div_n_sel) - 7'h01) ? 7'h00
                  : divn_cnt + 7'h01;
    end
  end

  // source change acts at once; no glitch-free switch, so one short period can occur
  always_comb begin
    next_osc_tick = 1'b0;
    unique case (src)
      OPS_FAST_RC: next_osc_tick = fast_rc_tick;
      OPS_FAST_RC_PLL, OPS_PRIMARY_PLL: begin
        next_osc_tick = pll_vco_tick && post_cnt >= postscale_factor - 4'h1;
      end
      OPS_PRIMARY: next_osc_tick = ref_tick;
      OPS_SECONDARY: next_osc_tick = secondary_osc_tick;
      OPS_LOW_POWER_RC: next_osc_tick = low_power_rc_tick;
      OPS_FAST_RC_DIV16: next_osc_tick = fast_rc_tick && div16_cnt >= DIV16_LAST;
      OPS_FAST_RC_DIV_N: begin
        next_osc_tick = fast_rc_tick && divn_cnt >= (7'h01 << fast_rc_div_n_sel) - 7'h01;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_tick <= 1'b0;
      instruction_clock <= 1'b0;
      instr_phase <= 1'b0;
    end else begin
      osc_tick <= next_osc_tick;
      instruction_clock <= next_osc_tick && instr_phase;
      if (next_osc_tick) begin
        instr_phase <= !instr_phase;
      end
    end
  end

  // analog side controls; crystal drive only while primary is the source
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pll_enable <= 1'b0;
      pll_feedback_factor <= 10'h000;
      primary_osc_drive <= OPS_PRIMARY_OFF;
    end else begin
      pll_enable <= src_pll;
      pll_feedback_factor <= mult_factor;
      primary_osc_drive <= src_primary ? primary_osc_mode_sel : OPS_PRIMARY_OFF;
    end
  end

  // crystal modes own the second pin while primary is the source; otherwise clock out or general i/o
  always_ff @(posedge sys_clk) begin
    logic crystal;
    crystal = src_primary && (primary_osc_mode_sel == OPS_HIGH_SPEED_CRYSTAL ||
                              primary_osc_mode_sel == OPS_STANDARD_CRYSTAL);
    if (rst) begin
      second_osc_pin_out <= 1'b0;
      second_osc_pin_oe <= 1'b0;
    end else if (crystal) begin
      second_osc_pin_out <= 1'b0;
      second_osc_pin_oe <= 1'b0;
    end else if (osc_pin_function_sel) begin
      second_osc_pin_out <= instr_phase;
      second_osc_pin_oe <= 1'b1;
    end else begin
      second_osc_pin_out <= osc_pin_gpio_out;
      second_osc_pin_oe <= osc_pin_gpio_oe;
    end
  end

  // frequency estimate; the divide is wide but only settles a status word
  // range flags only report; software must keep the vco limits
  always_ff @(posedge sys_clk) begin
    logic [33:0] ref_khz;
    logic [33:0] vin;
    logic [33:0] vout;
    ref_khz = src_primary ? {10'h0, primary_ref_khz} : {10'h0, FAST_RC_KHZ};
    vin = ref_khz / {28'h0, prescale_factor};
    vout = (ref_khz * {24'h0, mult_factor}) / {28'h0, prescale_factor};
    if (rst) begin
      osc_freq_khz <= 32'h00000000;
      vco_in_ok <= 1'b0;
      vco_out_ok <= 1'b0;
    end else begin
      vco_in_ok <= src_pll && vin >= VCO_IN_MIN_KHZ && vin <= VCO_IN_MAX_KHZ;
      vco_out_ok <= src_pll && vout >= VCO_OUT_MIN_KHZ && vout <= VCO_OUT_MAX_KHZ;
      unique case (src)
        OPS_FAST_RC_PLL, OPS_PRIMARY_PLL: begin
          osc_freq_khz <= 32'(vout / {30'h0, postscale_factor});
        end
        OPS_PRIMARY: osc_freq_khz <= 32'(ref_khz);
        OPS_FAST_RC: osc_freq_khz <= {8'h0, FAST_RC_KHZ};
        OPS_SECONDARY: osc_freq_khz <= {8'h0, SECONDARY_KHZ};
        OPS_LOW_POWER_RC: osc_freq_khz <= {8'h0, LOW_POWER_RC_KHZ};
        OPS_FAST_RC_DIV16: osc_freq_khz <= {12'h0, FAST_RC_KHZ[23:4]};
        OPS_FAST_RC_DIV_N: osc_freq_khz <= {8'h0, FAST_RC_KHZ >> fast_rc_div_n_sel};
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/ops_pkg.sv ***
// constants for the oscillator source and pll selection block
// assumes one 200 MHz system clock and a 32-bit avalon-mm slave port
package ops_pkg;
  localparam int unsigned SYS_CLK_MHZ = 200;
  localparam logic [4:0] OFS_OSC_CFG = 5'h00;
  localparam logic [4:0] OFS_PLL_CFG = 5'h04;
  localparam logic [4:0] OFS_FRC_DIV = 5'h08;
  localparam logic [4:0] OFS_REF_KHZ = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_FREQ = 5'h14;
  // osc_cfg fields
  localparam int SRC_LSB = 0;
  localparam int MODE_LSB = 3;
  localparam int PINFN_BIT = 5;
  // pll_cfg fields
  localparam int PRE_LSB = 0;
  localparam int MULT_LSB = 8;
  localparam int POST_LSB = 24;
  // erased part: fast rc with divide-by-n, primary off, pin as clock out
  localparam logic [2:0] SRC_RESET = 3'h7;
  localparam logic [1:0] MODE_RESET = 2'h3;
  localparam logic PINFN_RESET = 1'b1;
  localparam logic [4:0] PRE_RESET = 5'h00;
  localparam logic [8:0] MULT_RESET = 9'h01E;
  localparam logic [1:0] POST_RESET = 2'h0;
  localparam logic [2:0] FRC_DIV_RESET = 3'h0;
  localparam logic [23:0] REF_KHZ_RESET = 24'h002710;
  localparam logic [4:0] PRE_OFFSET = 5'h02;
  localparam logic [9:0] MULT_OFFSET = 10'h002;
  localparam logic [4:0] DIV16_LAST = 5'h0F;
  typedef enum logic [2:0] {
    OPS_FAST_RC = 3'b000,
    OPS_FAST_RC_PLL = 3'b001,
    OPS_PRIMARY = 3'b010,
    OPS_PRIMARY_PLL = 3'b011,
    OPS_SECONDARY = 3'b100,
    OPS_LOW_POWER_RC = 3'b101,
    OPS_FAST_RC_DIV16 = 3'b110,
    OPS_FAST_RC_DIV_N = 3'b111
  } ops_src_t;
  typedef enum logic [1:0] {
    OPS_EXTERNAL_CLOCK_INPUT = 2'b00,
    OPS_STANDARD_CRYSTAL = 2'b01,
    OPS_HIGH_SPEED_CRYSTAL = 2'b10,
    OPS_PRIMARY_OFF = 2'b11
  } ops_mode_t;
  // vco limits in kHz
  localparam logic [33:0] VCO_IN_MIN_KHZ = 34'd800;
  localparam logic [33:0] VCO_IN_MAX_KHZ = 34'd8000;
  localparam logic [33:0] VCO_OUT_MIN_KHZ = 34'd100000;
  localparam logic [33:0] VCO_OUT_MAX_KHZ = 34'd200000;
endpackage

// *** tb/ops_clock_select_props.sv ***
// assertions on the oscillator select ports, bound into the design
// assumes writes land at the edge that samples waitrequest low
`timescale 1ns/100ps
`default_nettype none
module ops_clock_select_props
  import ops_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic fast_rc_tick,
  input wire logic low_power_rc_tick,
  input wire logic secondary_osc_tick,
  input wire logic osc_tick,
  input wire logic instruction_clock,
  input wire logic pll_enable,
  input wire logic [9:0] pll_feedback_factor,
  input wire logic [1:0] primary_osc_drive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [2:0] src_q;
  logic [1:0] mode_q;
  logic [8:0] mult_q;
  logic [1:0] quiet;
  logic par;
  wire wr_ok = avs_write && !avs_waitrequest;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_q <= SRC_RESET;
      mode_q <= MODE_RESET;
    end else if (wr_ok && avs_address == OFS_OSC_CFG && avs_byteenable[0]) begin
      src_q <= avs_writedata[2:0];
      mode_q <= avs_writedata[4:3];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mult_q <= MULT_RESET;
    end else if (wr_ok && avs_address == OFS_PLL_CFG) begin
      if (avs_byteenable[1]) mult_q[7:0] <= avs_writedata[15:8];
      if (avs_byteenable[2]) mult_q[8] <= avs_writedata[16];
    end
  end
  // outputs settle a few edges after any write, so check only when quiet
  always_ff @(posedge sys_clk) begin
    if (rst || wr_ok) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) par <= 1'b0;
    else if (osc_tick) par <= !par;
  end
  a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_instr_half: assert property (osc_tick |-> instruction_clock == par)
    else $error("instruction clock not every second osc tick");
  a_pll_enable: assert property (quiet == 2'h3 |-> pll_enable == (src_q == 3'h1 || src_q == 3'h3))
    else $error("pll enable does not follow source");
  a_primary_drive: assert property (quiet == 2'h3 |->
    primary_osc_drive == ((src_q == 3'h2 || src_q == 3'h3) ? mode_q : 2'h3))
    else $error("primary drive does not follow mode");
  a_fb_factor: assert property (quiet == 2'h3 |-> pll_feedback_factor == {1'b0, mult_q} + 10'h002)
    else $error("feedback factor wrong");
  a_fast_direct: assert property (quiet == 2'h3 && src_q == 3'h0 |=> osc_tick == $past(fast_rc_tick))
    else $error("fast rc not passed straight");
  a_lp_direct: assert property (quiet == 2'h3 && src_q == 3'h5 |=> osc_tick == $past(low_power_rc_tick))
    else $error("low power rc not passed");
  a_sec_direct: assert property (quiet == 2'h3 && src_q == 3'h4 |=> osc_tick == $past(secondary_osc_tick))
    else $error("secondary osc not passed");
  a_reset_state: assert property (disable iff (1'b0) rst |=> avs_waitrequest && !pll_enable &&
    primary_osc_drive == 2'h3 && !osc_tick && !instruction_clock)
    else $error("outputs wrong after reset");
endmodule
bind ops_clock_select ops_clock_select_props ops_clock_select_props_inst (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .fast_rc_tick(fast_rc_tick),
  .low_power_rc_tick(low_power_rc_tick), .secondary_osc_tick(secondary_osc_tick),
  .osc_tick(osc_tick), .instruction_clock(instruction_clock), .pll_enable(pll_enable),
  .pll_feedback_factor(pll_feedback_factor), .primary_osc_drive(primary_osc_drive));
`default_nettype wire

// *** tb/ops_osc_model.sv ***
// oscillators and analog pll seen from the select block, as tick pulses
// assumes sys_clk is far faster than any modelled oscillator
`timescale 1ns/100ps
`default_nettype none
module ops_osc_model #(
  parameter int FAST_P = 3,
  parameter int LP_P = 7,
  parameter int SEC_P = 5,
  parameter int PRI_P = 4,
  parameter int VCO_P = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pll_enable,
  input wire logic [1:0] primary_osc_drive,
  output logic [4:0] tk
);
  int unsigned t;
  always_ff @(posedge sys_clk) begin
    t <= rst ? 0 : t + 1;
    tk[0] <= (t % FAST_P) == 0;
    tk[1] <= (t % LP_P) == 0;
    tk[2] <= (t % SEC_P) == 0;
    // crystal or external source stands still while its drive is off
    tk[3] <= primary_osc_drive != 2'h3 && (t % PRI_P) == 0;
    tk[4] <= pll_enable && (t % VCO_P) == 0;
  end
endmodule
`default_nettype wire

// *** tb/test_oscillator_source_pll_select.sv ***
// self-checking bench: register port, tick ratios per source, pll frequency
// assumes ops_osc_model supplies the oscillator ticks
`timescale 1ns/100ps
`default_nettype none
module test_oscillator_source_pll_select;
  import ops_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic osc_pin_gpio_out = 1'b0;
  logic osc_pin_gpio_oe = 1'b0;
  logic [31:0] avs_readdata, q;
  logic [31:0] seed = 32'hEF08;
  logic avs_waitrequest, osc_tick, instruction_clock, pll_ref_tick, pll_enable;
  logic second_osc_pin_out, second_osc_pin_oe, clr = 1'b0;
  logic [9:0] pll_feedback_factor;
  logic [1:0] primary_osc_drive;
  wire [4:0] tk;
  int errors, cmp_count, s, m, n, n_osc, n_ins, n_ref;
  int n_src [5];
  ops_osc_model ops_osc_model_inst (.sys_clk(sys_clk), .rst(rst), .pll_enable(pll_enable),
    .primary_osc_drive(primary_osc_drive), .tk(tk));
  ops_clock_select ops_clock_select_inst (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fast_rc_tick(tk[0]), .low_power_rc_tick(tk[1]), .secondary_osc_tick(tk[2]),
    .primary_osc_tick(tk[3]), .pll_vco_tick(tk[4]), .osc_pin_gpio_out(osc_pin_gpio_out),
    .osc_pin_gpio_oe(osc_pin_gpio_oe), .osc_tick(osc_tick),
    .instruction_clock(instruction_clock), .pll_ref_tick(pll_ref_tick),
    .pll_enable(pll_enable), .pll_feedback_factor(pll_feedback_factor),
    .primary_osc_drive(primary_osc_drive), .second_osc_pin_out(second_osc_pin_out),
    .second_osc_pin_oe(second_osc_pin_oe));
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    for (int i = 0; i < 5; i++) n_src[i] <= clr ? 0 : n_src[i] + tk[i];
    n_osc <= clr ? 0 : n_osc + osc_tick;
    n_ins <= clr ? 0 : n_ins + instruction_clock;
    n_ref <= clr ? 0 : n_ref + pll_ref_tick;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // which tick feeds the oscillator for a source code, and by how much it is divided
  function automatic int src_of(input int c);
    case (c)
      0, 6, 7: return 0;
      1, 3: return 4;
      2: return 3;
      4: return 2;
      default: return 1;
    endcase
  endfunction
  function automatic int div_of(input int c, input int dn);
    case (c)
      6: return 16;
      7: return 1 << dn;
      1, 3: return 2;
      default: return 1;
    endcase
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // tick counts carry a phase error of up to one divided period
  task automatic ratio(input int got, input int exp, input int tol);
    cmp_count++;
    if (got > exp + tol || got + tol < exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // no cycle limit here; only the watchdog ends a stalled request
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    cmp(q, e);
  endtask
  task automatic run();
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (480) @(posedge sys_clk);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFS_OSC_CFG, 32'h3F);
    rd(OFS_PLL_CFG, 32'h1E00);
    rd(OFS_FRC_DIV, 32'h0);
    rd(OFS_REF_KHZ, 32'h2710);
    rd(OFS_FREQ, 32'd8000);
    rd(5'h18, 32'h0);
    $display("test reset values done");
    for (s = 0; s < 8; s++) begin
      m = rnd() % 3;
      wr(OFS_OSC_CFG, {26'h0, 1'b1, m[1:0], s[2:0]});
      run();
      ratio(n_osc * div_of(s, 0), n_src[src_of(s)], div_of(s, 0));
      ratio(n_ins * 2, n_osc, 2);
    end
    for (n = 1; n < 4; n++) begin
      wr(OFS_FRC_DIV, n);
      run();
      ratio(n_osc * (1 << n), n_src[0], 1 << n);
    end
    bus(1'b1, OFS_FRC_DIV, 32'h0, 4'hE);
    rd(OFS_FRC_DIV, 32'h3);
    $display("test source table done");
    wr(OFS_REF_KHZ, 32'd10000);
    wr(OFS_OSC_CFG, 32'h0B);
    run();
    ratio(n_ref * 2, n_src[3], 2);
    rd(OFS_FREQ, 32'd80000);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    cmp(q & 32'h1C, 32'h1C);
    wr(OFS_PLL_CFG, 32'h1E03);
    rd(OFS_FREQ, 32'd32000);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    cmp(q & 32'h1C, 32'h0C);
    wr(OFS_PLL_CFG, 32'h01001E00);
    rd(OFS_FREQ, 32'd40000);
    for (n = 0; n < 4; n++) begin
      m = 18 + rnd() % 21;
      wr(OFS_PLL_CFG, m << 8);
      rd(OFS_PLL_CFG, m << 8);
      cmp(pll_feedback_factor, m + 2);
      rd(OFS_FREQ, 2500 * (m + 2));
    end
    $display("test pll done");
    wr(OFS_OSC_CFG, 32'h00);
    for (n = 0; n < 4; n++) begin
      m = rnd();
      @(posedge sys_clk);
      osc_pin_gpio_out <= m[0];
      osc_pin_gpio_oe <= m[1];
      repeat (3) @(posedge sys_clk);
      cmp({second_osc_pin_oe, second_osc_pin_out}, m[1:0]);
    end
    wr(OFS_OSC_CFG, 32'h20);
    repeat (3) @(posedge sys_clk);
    cmp(second_osc_pin_oe, 1'b1);
    wr(OFS_OSC_CFG, 32'h0A);
    repeat (3) @(posedge sys_clk);
    cmp(second_osc_pin_oe, 1'b0);
    bus(1'b1, OFS_OSC_CFG, 32'h0, 4'hE);
    rd(OFS_OSC_CFG, 32'h0A);
    wr(OFS_FREQ, 32'h0);
    rd(OFS_FREQ, 32'd10000);
    $display("test pin and access done");
    print_verdict();
  end
endmodule
`default_nettype wire
